// ===== logic/dcs_top.sv
/*
  dcs_top: dynamic clock switch control, enables, readiness count,
  glitch-free system clock gate selection and clock output pin.
  assumes source clocks and the divided system clock arrive as pins and
  are sampled on clk_sys_i; the analog gates act on sys_gate_o.
*/
// How it works
// - external clock starts in six cycles
// - reset delay: 14 cycles plus fuse ms
// - timer gets external clock only without crystals
// - clock out when fuse or bit set and no crystal enabled
// - no clock out in reset; overrides port
// - clock out carries the divided clock
// - commands need the protected two-write sequence
// - one decoded command launched at a time
// - reset loads select fields from fuses
// - select fields supply command operands
// - enable turns on source with startup
// - disable skips the current system source
// - each source latches its own enable
// - ready count runs on selected source
// - ready cleared at count start, held
// - enable starts the ready count itself
// - recover writes current source code only
// - five selectable system clock sources
// - system gates change glitch-free under deglitching
// - switch is 04, disable is 01
// - recover is 05, enable is 02
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
#(
  parameter int RST_S_CYCLES = RST_S_CYC,
  parameter int RST_L_CYCLES = RST_L_CYC
)(
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic [3:0]      fuse_source_sel_i,
  input  wire logic [1:0]      fuse_startup_i,
  input  wire logic            fuse_clock_output_i,
  input  wire logic            reset_pin_disable_fuse_i,
  input  wire logic            cmd_wr_i,
  input  wire logic [CMD_W-1:0] cmd_data_i,
  input  wire logic            sel_wr_i,
  input  wire dcs_sel_t        sel_data_i,
  input  wire logic [NSRC-1:0] src_clk_i,
  input  wire logic            sys_clk_div_i,
  input  wire logic            timer_ext_req_i,
  output dcs_sel_t             clock_select_reg_o,
  output logic                 source_ready_flag_o,
  output logic                 count_busy_o,
  output logic [NSRC-1:0]      source_en_o,
  output logic [NSRC-1:0]      sys_gate_o,
  output logic [3:0]           sys_src_code_o,
  output logic                 switch_busy_o,
  output logic                 wd_auto_reload_o,
  output logic                 timer_ext_grant_o,
  output logic                 clock_out_pin_o,
  output logic                 clock_out_oe_o,
  output logic                 reset_delay_done_o
);

  function automatic logic [2:0] src_of(input logic [3:0] code);
    if (code[3])
      src_of = 3'(SRC_XTAL);
    else if (code == CODE_EXT)
      src_of = 3'(SRC_EXT);
    else if (code == CODE_WD)
      src_of = 3'(SRC_WD);
    else if (code == CODE_LF)
      src_of = 3'(SRC_LF);
    else
      src_of = 3'(SRC_RC);
  endfunction : src_of

  // start-up count limit; zero marks a reserved setting
  function automatic logic [15:0] limit_of(input logic [3:0] code,
                                           input logic [1:0] sut);
    logic [2:0] s;
    s = src_of(code);
    limit_of = SU_INT;
    if (s == 3'(SRC_EXT))
      limit_of = (sut == SUT_RSVD) ? 16'h0000 : SU_EXT;
    else if (s == 3'(SRC_LF))
    begin
      if (sut == SUT_RSVD)
        limit_of = 16'h0000;
      else
        limit_of = sut[1] ? SU_32K : SU_1K;
    end
    else if (s == 3'(SRC_XTAL))
    begin
      if (code[0])
        limit_of = SU_16K;
      else
        limit_of = sut[1] ? SU_1K : SU_258;
    end
  endfunction : limit_of

  // synchronisers; the third stage only feeds edge detection
  logic [NSRC:0] sync1_reg, sync2_reg, sync3_reg;
  logic          treq1_reg, treq2_reg;
  always_ff @(posedge clk_sys_i)
  begin
    sync1_reg <= {sys_clk_div_i, src_clk_i};
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
    // the timer runs on its own clock, so its request is synchronised too
    treq1_reg <= timer_ext_req_i;
    treq2_reg <= treq1_reg;
  end

  logic [NSRC-1:0] src_lvl, src_rise;
  assign src_lvl  = sync2_reg[NSRC-1:0];
  assign src_rise = sync2_reg[NSRC-1:0] & ~sync3_reg[NSRC-1:0];

  dcs_sel_t        sel_reg, sel_next;
  logic [2:0]      cce_reg, cce_next;
  logic [NSRC-1:0] en_reg, en_next;
  logic [NSRC-1:0] gate_reg, gate_next;
  logic [3:0]      cur_reg, cur_next;
  logic [3:0]      tgt_reg, tgt_next;
  dcs_sw_t         sw_reg, sw_next;
  logic            rdy_reg, rdy_next;
  logic            busy_reg, busy_next;
  logic [2:0]      csrc_reg, csrc_next;
  logic [15:0]     cnt_reg, cnt_next;
  logic [15:0]     lim_reg, lim_next;
  logic            arl_reg, arl_next;

  logic            cmd_ok;
  logic [3:0]      cmd;
  logic [2:0]      sel_src, cur_src, tgt_src;

  assign cmd_ok  = cmd_wr_i && !cmd_data_i[CCE_BIT] && (cce_reg != 3'h0);
  assign cmd     = cmd_ok ? cmd_data_i[3:0] : 4'h0;
  assign sel_src = src_of(sel_reg.source_sel_field);
  assign cur_src = src_of(cur_reg);
  assign tgt_src = src_of(tgt_reg);

  always_comb
  begin
    sel_next  = sel_reg;
    cce_next  = (cce_reg != 3'h0) ? cce_reg - 3'h1 : 3'h0;
    en_next   = en_reg;
    gate_next = gate_reg;
    cur_next  = cur_reg;
    tgt_next  = tgt_reg;
    sw_next   = sw_reg;
    rdy_next  = rdy_reg;
    busy_next = busy_reg;
    csrc_next = csrc_reg;
    cnt_next  = cnt_reg;
    lim_next  = lim_reg;
    arl_next  = arl_reg;

    // a lone write with the change enable only opens the window
    if (cmd_wr_i && cmd_data_i[CCE_BIT])
      cce_next = CCE_WINDOW;
    else if (cmd_wr_i)
      cce_next = 3'h0;

    if (sel_wr_i)
      sel_next = sel_data_i;

    // readiness count, one step per rising edge of the chosen source
    if (busy_reg && src_rise[csrc_reg])
    begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_reg + 16'h0001 >= lim_reg)
      begin
        rdy_next  = 1'b1;
        busy_next = 1'b0;
      end
    end

    // glitch-free handover: old gate drops while old clock is low,
    // new gate rises while new clock is low
    case (sw_reg)
      SW_IDLE: ;
      SW_OLD_LOW:
        if (!src_lvl[cur_src])
        begin
          gate_next = '0;
          sw_next   = SW_NEW_LOW;
        end
      SW_NEW_LOW:
        if (!src_lvl[tgt_src])
        begin
          gate_next          = '0;
          gate_next[tgt_src] = 1'b1;
          cur_next           = tgt_reg;
          sw_next            = SW_IDLE;
        end
      default: sw_next = SW_IDLE;
    endcase

    // only one decoded command acts per accepted write
    case (cmd)
      CMD_DISABLE:
        if (sel_src != cur_src && !(sw_reg != SW_IDLE && sel_src == tgt_src))
          en_next[sel_src] = 1'b0;
      CMD_ENABLE:
        if (limit_of(sel_reg.source_sel_field, sel_reg.startup_sel_field) != 16'h0000)
        begin
          en_next[sel_src] = 1'b1;
          rdy_next  = 1'b0;
          busy_next = 1'b1;
          cnt_next  = 16'h0000;
          csrc_next = sel_src;
          lim_next  = limit_of(sel_reg.source_sel_field, sel_reg.startup_sel_field);
        end
      CMD_REQUEST:
        if (limit_of(sel_reg.source_sel_field, sel_reg.startup_sel_field) != 16'h0000)
        begin
          rdy_next  = 1'b0;
          busy_next = 1'b1;
          cnt_next  = 16'h0000;
          csrc_next = sel_src;
          lim_next  = limit_of(sel_reg.source_sel_field, sel_reg.startup_sel_field);
        end
      CMD_SWITCH:
        if (sw_reg == SW_IDLE && en_reg[sel_src] && sel_src != cur_src)
        begin
          tgt_next = sel_reg.source_sel_field;
          sw_next  = SW_OLD_LOW;
        end
      CMD_RECOVER:
        if (!sel_wr_i)
          sel_next.source_sel_field = cur_reg;
      CMD_WD_ARL:
        arl_next = 1'b1;
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      // fuses are static straps, so the reset load reads them directly
      sel_reg.source_sel_field <= fuse_source_sel_i;
      sel_reg.startup_sel_field <= fuse_startup_i;
      sel_reg.clock_output_bit <= ~fuse_clock_output_i;
      cce_reg      <= 3'h0;
      en_reg       <= '0;
      en_reg[src_of(fuse_source_sel_i)]   <= 1'b1;
      gate_reg     <= '0;
      gate_reg[src_of(fuse_source_sel_i)] <= 1'b1;
      cur_reg      <= fuse_source_sel_i;
      tgt_reg      <= fuse_source_sel_i;
      sw_reg       <= SW_IDLE;
      rdy_reg      <= 1'b0;
      busy_reg     <= 1'b0;
      csrc_reg     <= 3'h0;
      cnt_reg      <= 16'h0000;
      lim_reg      <= 16'h0000;
      arl_reg      <= 1'b0;
    end
    else
    begin
      sel_reg  <= sel_next;
      cce_reg  <= cce_next;
      en_reg   <= en_next;
      gate_reg <= gate_next;
      cur_reg  <= cur_next;
      tgt_reg  <= tgt_next;
      sw_reg   <= sw_next;
      rdy_reg  <= rdy_next;
      busy_reg <= busy_next;
      csrc_reg <= csrc_next;
      cnt_reg  <= cnt_next;
      lim_reg  <= lim_next;
      arl_reg  <= arl_next;
    end
  end

  // additional delay from reset: 14 source cycles, then the fuse time
  dcs_rd_t     rd_reg, rd_next;
  logic [3:0]  rck_reg, rck_next;
  logic [23:0] rms_reg, rms_next;
  logic [23:0] rms_lim;
  logic [2:0]  fsrc;

  assign fsrc = src_of(fuse_source_sel_i);

  always_comb
  begin
    rms_lim = 24'h000000;
    if (fsrc == 3'(SRC_EXT))
    begin
      if (fuse_startup_i == 2'h1
          || (fuse_startup_i == 2'h0 && reset_pin_disable_fuse_i))
        rms_lim = 24'(RST_S_CYCLES);
      else if (fuse_startup_i == 2'h2)
        rms_lim = 24'(RST_L_CYCLES);
    end
  end

  always_comb
  begin
    rd_next  = rd_reg;
    rck_next = rck_reg;
    rms_next = rms_reg;
    case (rd_reg)
      RD_CK:
        if (src_rise[fsrc])
        begin
          rck_next = rck_reg + 4'h1;
          if (rck_reg + 4'h1 >= RST_CK)
            rd_next = (rms_lim == 24'h000000) ? RD_DONE : RD_MS;
        end
      RD_MS:
      begin
        rms_next = rms_reg + 24'h000001;
        if (rms_reg + 24'h000001 >= rms_lim)
          rd_next = RD_DONE;
      end
      RD_DONE: ;
      default: rd_next = RD_CK;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_reg  <= RD_CK;
      rck_reg <= 4'h0;
      rms_reg <= 24'h000000;
    end
    else
    begin
      rd_reg  <= rd_next;
      rck_reg <= rck_next;
      rms_reg <= rms_next;
    end
  end

  // clock output pin and timer grant
  logic xtal_run;
  logic ck_pin_reg, ck_pin_next;
  logic ck_oe_reg, ck_oe_next;
  logic grant_reg, grant_next;

  assign xtal_run = en_reg[SRC_XTAL] | en_reg[SRC_LF];

  always_comb
  begin
    // grant waits on a crystal switching off; the pins are shared
    grant_next  = treq2_reg && !xtal_run;
    ck_oe_next  = !xtal_run
                  && (!fuse_clock_output_i || sel_reg.clock_output_bit);
    // the prescaled clock, not the raw source, reaches the pin
    ck_pin_next = sync2_reg[NSRC] && ck_oe_next;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      grant_reg  <= 1'b0;
      ck_oe_reg  <= 1'b0;
      ck_pin_reg <= 1'b0;
    end
    else
    begin
      grant_reg  <= grant_next;
      ck_oe_reg  <= ck_oe_next;
      ck_pin_reg <= ck_pin_next;
    end
  end

  assign clock_select_reg_o  = sel_reg;
  assign source_ready_flag_o = rdy_reg;
  assign count_busy_o        = busy_reg;
  assign source_en_o         = en_reg | (NSRC'(grant_reg) << SRC_EXT);
  assign sys_gate_o          = gate_reg;
  assign sys_src_code_o      = cur_reg;
  assign switch_busy_o       = (sw_reg != SW_IDLE);
  assign wd_auto_reload_o    = arl_reg;
  assign timer_ext_grant_o   = grant_reg;
  assign clock_out_pin_o     = ck_pin_reg;
  // while high the pin's port function is overridden
  assign clock_out_oe_o      = ck_oe_reg;
  assign reset_delay_done_o  = (rd_reg == RD_DONE);

endmodule : dcs_top

// ===== common/dcs_pkg.sv
/*
  dcs_pkg: constants and types for the dynamic clock switch.
  assumes one system clock at 250 MHz; source codes are 4-bit select codes.
*/
package dcs_pkg;

  localparam int CLK_MHZ = 250;

  // clock_select_reg layout: clock_output_bit | startup | source
  typedef struct packed {
    logic       clock_output_bit;
    logic [1:0] startup_sel_field;
    logic [3:0] source_sel_field;
  } dcs_sel_t;

  localparam int SEL_W       = 7;
  localparam int CMD_W       = 8;
  localparam int CCE_BIT     = 7;
  localparam int SOURCE_SEL_FIELD_LSB    = 0;
  localparam int STARTUP_SEL_FIELD_LSB    = 4;
  localparam int CLOCK_OUTPUT_BIT_BIT    = 6;

  // command codes in the low nibble of a command write
  localparam logic [3:0] CMD_DISABLE = 4'h1;
  localparam logic [3:0] CMD_ENABLE  = 4'h2;
  localparam logic [3:0] CMD_REQUEST = 4'h3;
  localparam logic [3:0] CMD_SWITCH  = 4'h4;
  localparam logic [3:0] CMD_RECOVER = 4'h5;
  localparam logic [3:0] CMD_WD_ARL  = 4'h6;

  // cycles a protected-write window stays open after the change enable
  localparam logic [2:0] CCE_WINDOW  = 3'h4;

  // source indices
  localparam int NSRC     = 5;
  localparam int SRC_RC   = 0;
  localparam int SRC_WD   = 1;
  localparam int SRC_EXT  = 2;
  localparam int SRC_LF   = 3;
  localparam int SRC_XTAL = 4;

  // source select codes; any code with bit 3 set is the crystal oscillator
  localparam logic [3:0] CODE_EXT = 4'h0;
  localparam logic [3:0] CODE_RC  = 4'h2;
  localparam logic [3:0] CODE_WD  = 4'h3;
  localparam logic [3:0] CODE_LF  = 4'h6;

  // start-up counts in source clock cycles
  localparam logic [15:0] SU_EXT   = 16'h0006;
  localparam logic [15:0] SU_INT   = 16'h0006;
  localparam logic [15:0] SU_258   = 16'h0102;
  localparam logic [15:0] SU_1K    = 16'h0400;
  localparam logic [15:0] SU_16K   = 16'h4000;
  localparam logic [15:0] SU_32K   = 16'h8000;
  localparam logic [1:0]  SUT_RSVD = 2'h3;

  // additional delay from reset
  localparam logic [3:0] RST_CK       = 4'he;
  localparam int         T_RST_S_US   = 4100;
  localparam int         T_RST_L_US   = 65000;
  localparam int         RST_S_CYC    = T_RST_S_US * CLK_MHZ;
  localparam int         RST_L_CYC    = T_RST_L_US * CLK_MHZ;

  typedef enum logic [1:0] {SW_IDLE, SW_OLD_LOW, SW_NEW_LOW} dcs_sw_t;
  typedef enum logic [1:0] {RD_CK, RD_MS, RD_DONE} dcs_rd_t;

endpackage : dcs_pkg

// ===== verification/dcs_top_chk.sv
/*
  dcs_top_chk: port assertions for the dynamic clock switch.
  assumes binding to dcs_top; sees its ports only.
*/
`timescale 1ns/1ps
module dcs_top_chk
  import dcs_pkg::*;
#(
  parameter int RST_S_CYCLES = 20,
  parameter int RST_L_CYCLES = 40
)(
  input wire logic             clk_sys_i,
  input wire logic             rst_i,
  input wire logic             cmd_wr_i,
  input wire logic [CMD_W-1:0] cmd_data_i,
  input wire logic             sel_wr_i,
  input wire logic             timer_ext_req_i,
  input wire dcs_sel_t         clock_select_reg_o,
  input wire logic             source_ready_flag_o,
  input wire logic             count_busy_o,
  input wire logic [NSRC-1:0]  source_en_o,
  input wire logic [NSRC-1:0]  sys_gate_o,
  input wire logic [3:0]       sys_src_code_o,
  input wire logic             switch_busy_o,
  input wire logic             timer_ext_grant_o,
  input wire logic             clock_out_pin_o,
  input wire logic             clock_out_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // reset itself is the cause here, so it cannot disable the check
  AST_OE_RST: assert property (disable iff (1'b0)
    rst_i |=> !clock_out_oe_o && !clock_out_pin_o) else $error("clock out in reset");
  AST_PIN_OFF: assert property (
    !clock_out_oe_o && !$past(clock_out_oe_o) |-> !clock_out_pin_o)
    else $error("pin toggles while output disabled");
  AST_OE_XTAL: assert property ((|source_en_o[4:3]) [*2] |-> !clock_out_oe_o)
    else $error("clock out with crystal running");
  AST_GRANT: assert property (
    !timer_ext_req_i [*4] |-> !timer_ext_grant_o)
    else $error("timer granted without a request");
  AST_GRANT_XTAL: assert property (
    (|source_en_o[4:3]) [*2] |-> !timer_ext_grant_o)
    else $error("timer granted with a crystal running");
  AST_READY_DROP: assert property ($fell(source_ready_flag_o) |-> count_busy_o)
    else $error("ready dropped without a count");
  AST_READY_SET: assert property (
    $rose(source_ready_flag_o) |-> $fell(count_busy_o)) else $error("ready not at count end");
  AST_GATE_ONEHOT: assert property ($onehot0(sys_gate_o))
    else $error("two system gates open");
  AST_GATE_STILL: assert property (
    !switch_busy_o && !$past(switch_busy_o) && !$past(rst_i) |-> $stable(sys_gate_o))
    else $error("gate moved outside a handover");
  AST_SWITCH_END: assert property ($fell(switch_busy_o) |-> $onehot(sys_gate_o))
    else $error("handover ended without a gate");
  AST_RECOVER: assert property (
    (cmd_wr_i && cmd_data_i == 8'h80) ##1 (cmd_wr_i && cmd_data_i == 8'h05 && !sel_wr_i)
    |=> clock_select_reg_o.source_sel_field == $past(sys_src_code_o)) else $error("recover code wrong");
  AST_ENABLE: assert property (
    (cmd_wr_i && cmd_data_i == 8'h80) ##1 (cmd_wr_i && cmd_data_i == 8'h02 && !sel_wr_i
    && clock_select_reg_o.startup_sel_field != 2'h3) |=> count_busy_o && !source_ready_flag_o)
    else $error("enable did not start a count");
  cover property ($rose(source_ready_flag_o));
  cover property ($fell(switch_busy_o));
  cover property (timer_ext_grant_o);
endmodule : dcs_top_chk

bind dcs_top dcs_top_chk #(.RST_S_CYCLES(RST_S_CYCLES), .RST_L_CYCLES(RST_L_CYCLES)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i), .cmd_data_i(cmd_data_i),
  .sel_wr_i(sel_wr_i), .timer_ext_req_i(timer_ext_req_i),
  .clock_select_reg_o(clock_select_reg_o), .source_ready_flag_o(source_ready_flag_o),
  .count_busy_o(count_busy_o), .source_en_o(source_en_o), .sys_gate_o(sys_gate_o),
  .sys_src_code_o(sys_src_code_o), .switch_busy_o(switch_busy_o),
  .timer_ext_grant_o(timer_ext_grant_o), .clock_out_pin_o(clock_out_pin_o),
  .clock_out_oe_o(clock_out_oe_o));

// ===== verification/dcs_top_tb.sv
/*
  dcs_top_tb: self-checking bench for the dynamic clock switch.
  assumes free-running source clocks and shortened reset delays.
*/
`timescale 1ns/1ps
module dcs_top_tb;
  import dcs_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  fsel = 4'h2;
  logic [1:0]  fsut = 2'h0;
  logic        fco = 1'b0;
  logic        cmd_wr_i = 1'b0;
  logic        sel_wr_i = 1'b0;
  logic        treq = 1'b0;
  logic        rpd = 1'b0;
  logic        div = 1'b0;
  logic [7:0]  cmd_data_i = 8'h00;
  dcs_sel_t    sel_data_i = '0;
  logic [4:0]  src = 5'h00;
  logic [15:0] lfsr = 16'h7d8b;
  dcs_sel_t    csr;
  logic        rdy, busy, swb, arl, gnt, pin, oe, rdd;
  logic [4:0]  en, gate;
  logic [3:0]  code;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t;

  initial forever #2 clk_sys_i = ~clk_sys_i;
  // unrelated periods so handovers meet every phase
  always #5 src[0] = ~src[0];
  always #13 src[1] = ~src[1];
  always #7 src[2] = ~src[2];
  always #17 src[3] = ~src[3];
  always #9 src[4] = ~src[4];
  always #10 div = ~div;

  dcs_top #(.RST_S_CYCLES(20), .RST_L_CYCLES(40)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .fuse_source_sel_i(fsel),
    .fuse_startup_i(fsut), .fuse_clock_output_i(fco),
    .reset_pin_disable_fuse_i(rpd), .cmd_wr_i(cmd_wr_i),
    .cmd_data_i(cmd_data_i), .sel_wr_i(sel_wr_i), .sel_data_i(sel_data_i),
    .src_clk_i(src), .sys_clk_div_i(div), .timer_ext_req_i(treq),
    .clock_select_reg_o(csr), .source_ready_flag_o(rdy),
    .count_busy_o(busy), .source_en_o(en), .sys_gate_o(gate),
    .sys_src_code_o(code), .switch_busy_o(swb), .wd_auto_reload_o(arl),
    .timer_ext_grant_o(gnt), .clock_out_pin_o(pin),
    .clock_out_oe_o(oe), .reset_delay_done_o(rdd));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  function automatic logic [4:0] src_oh(input logic [3:0] c);
    if (c[3])
      return 5'h10;
    case (c)
      4'h0: return 5'h04;
      4'h3: return 5'h02;
      4'h6: return 5'h08;
      default: return 5'h01;
    endcase
  endfunction : src_oh

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask : step

  task automatic cmd(input logic [3:0] c);
    step();
    cmd_wr_i = 1'b1;
    cmd_data_i = 8'h80;
    step();
    cmd_data_i = {4'h0, c};
    step();
    cmd_wr_i = 1'b0;
  endtask : cmd

  task automatic sel(input logic [3:0] c, input logic [1:0] s, input logic o);
    step();
    sel_wr_i = 1'b1;
    sel_data_i = '{clock_output_bit: o, startup_sel_field: s, source_sel_field: c};
    step();
    sel_wr_i = 1'b0;
  endtask : sel

  // 0 reset delay done, 1 ready flag, otherwise switch busy
  function automatic logic pick(input int w);
    case (w)
      0: return rdd;
      1: return rdy;
      default: return swb;
    endcase
  endfunction : pick

  // a wait that never ends is a failure, not a silent pass
  task automatic wait_for(input int w, input logic v, output int n);
    n = 0;
    while (pick(w) !== v)
    begin
      step();
      n++;
      if (n == 1000)
      begin
        errors++;
        tally_and_finish();
      end
    end
  endtask : wait_for

  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (5) step();
    rst_i = 1'b0;
    chk("sel", csr, 7'h42);
    chk("gate", {gate, en}, {src_oh(4'h2), src_oh(4'h2)});
    wait_for(0, 1'b1, t);
    chk("rdly", 16'(t >= 30 && t < 100), 16'h1);
    chk("oe", oe, 1'b1);
    t = 0;
    repeat (20)
    begin
      step();
      t += pin;
    end
    chk("pin", 16'(t > 4 && t < 16), 16'h1);
    // random single writes never carry the arming bit
    repeat (16)
    begin
      lfsr = lfsr_next(lfsr);
      step();
      cmd_wr_i = 1'b1;
      cmd_data_i = {1'b0, lfsr[6:0]};
      step();
      cmd_wr_i = 1'b0;
      chk("unarmed", {en, code}, {5'h01, 4'h2});
    end
    sel(4'h3, lfsr[1:0] % 3, 1'b1);
    step();
    cmd_wr_i = 1'b1;
    cmd_data_i = 8'h80;
    step();
    cmd_wr_i = 1'b0;
    repeat (4) step();
    cmd_wr_i = 1'b1;
    cmd_data_i = 8'h02;
    step();
    cmd_wr_i = 1'b0;
    chk("expired", en, 5'h01);
    cmd(4'h2);
    chk("en_wd", {en, busy, rdy}, {5'h03, 2'b10});
    wait_for(1, 1'b1, t);
    chk("wd_time", 16'(t >= 30), 16'h1);
    sel(4'h2, 2'h0, 1'b1);
    cmd(4'h3);
    chk("req", {busy, rdy}, 2'b10);
    wait_for(1, 1'b1, t);
    chk("req_done", busy, 1'b0);
    lfsr = lfsr_next(lfsr);
    sel(4'h0, lfsr[1:0] % 3, 1'b1);
    cmd(4'h2);
    wait_for(1, 1'b1, t);
    chk("ext_time", 16'(t >= 17 && t < 60), 16'h1);
    cmd(4'h4);
    chk("sw_busy", swb, 1'b1);
    wait_for(2, 1'b0, t);
    chk("sw_done", {gate, code}, {src_oh(4'h0), 4'h0});
    sel(4'h3, 2'h1, 1'b1);
    cmd(4'h5);
    chk("recover", csr, 7'h50);
    sel(4'h0, 2'h0, 1'b1);
    cmd(4'h1);
    chk("dis_cur", en, 5'h07);
    sel(4'h3, 2'h0, 1'b1);
    cmd(4'h1);
    chk("dis_wd", en, 5'h05);
    cmd(4'h6);
    chk("arl", arl, 1'b1);
    treq = 1'b1;
    repeat (3) step();
    chk("grant", gnt, 1'b1);
    sel(4'h6, 2'h0, 1'b1);
    cmd(4'h2);
    repeat (3) step();
    chk("lf_on", {gnt, oe}, 2'b00);
    cmd(4'h1);
    repeat (3) step();
    chk("lf_off", {gnt, oe}, 2'b11);
    // second reset: external clock fuses, short delay code, output fuse off
    rst_i = 1'b1;
    fsel = 4'h0;
    fsut = 2'h1;
    fco = 1'b1;
    repeat (5) step();
    chk("rst_out", {oe, pin}, 2'b00);
    rst_i = 1'b0;
    chk("sel2", {csr, gate}, {7'h10, src_oh(4'h0)});
    wait_for(0, 1'b1, t);
    chk("rdly2", 16'(t >= 65 && t < 130), 16'h1);
    // code 00 gains the short delay only with the reset pin disabled
    rst_i = 1'b1;
    fsut = 2'h0;
    rpd = 1'b1;
    repeat (5) step();
    rst_i = 1'b0;
    wait_for(0, 1'b1, t);
    chk("rdly3", 16'(t >= 65 && t < 130), 16'h1);
    tally_and_finish();
  end
endmodule : dcs_top_tb
